// file: hdl/fcp_pkg.sv
package fcp_pkg;
  // Notes on behaviour
  // RQ1: perp low bits change only when unlocked
  // RQ2: sense reports present cylinder of drive
  // RQ3: poll disable stops the drive polling
  // RQ4: precomp starts at programmable 8-bit track
  // RQ5: start sector is first sector accessed, except format which starts at sector 1
  // RQ6: relative seek steps delta from present cylinder
  // RQ7: format writes sectors_per_track headers
  // RQ8: verify with count enable checks sectors_per_track
  // RQ9: read skips deleted sectors when bypass set
  // RQ10: read deleted takes only deleted sectors when bypass set
  // RQ11: bypass clear means no sector skipped
  // RQ12: step interval 0.5 to 8 ms
  // RQ13: four result bytes captured after command
  // RQ14: result bytes readable in result phase
  // RQ15: write gate timing shifted for pre-erase
  // RQ16: dual head continues onto head 1
  // RQ17: sector bytes are 128 shifted by code
  // RQ18: programmed io interrupts, else dma request
  // RQ19: present cylinder kept per drive
  // RQ20: host reads all results before next command; core accepts a new command when idle, results read or not

  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned HALF_MS_NS        = 500000;
  localparam int unsigned HALF_MS_CYC       = HALF_MS_NS / CLK_PERIOD_NS;
  localparam int unsigned DRIVES            = 2;
  localparam int unsigned SECTOR_BASE_BYTES = 128;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PERP   = 8'h01;
  localparam logic [7:0] OFF_PRECOMP_START_TRACK = 8'h02;
  localparam logic [7:0] OFF_STEP   = 8'h03;
  localparam logic [7:0] OFF_SECTOR = 8'h04;
  localparam logic [7:0] OFF_SPT    = 8'h05;
  localparam logic [7:0] OFF_SIZE   = 8'h06;
  localparam logic [7:0] OFF_DELTA  = 8'h07;
  localparam logic [7:0] OFF_CMD    = 8'h08;
  localparam logic [7:0] OFF_RES0   = 8'h09;
  localparam logic [7:0] OFF_RES3   = 8'h0c;
  localparam logic [7:0] OFF_STAT   = 8'h0d;
  localparam logic [7:0] OFF_PCN    = 8'h0e;

  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] SECTOR_RST = 8'h01;
  localparam logic [7:0] SPT_RST    = 8'h01;
  localparam logic [3:0] STEP_RST   = 4'hf;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0, CMD_READ = 3'h1, CMD_READ_DEL = 3'h2, CMD_WRITE = 3'h3,
    CMD_FORMAT = 3'h4, CMD_VERIFY = 3'h5, CMD_SEEK_REL = 3'h6, CMD_SENSE = 3'h7
  } fcp_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_STEP = 5'h02, ST_SEC = 5'h04, ST_DATA = 5'h08, ST_RES = 5'h10
  } fcp_state_t;

  typedef struct packed {
    logic poll_disable;
    logic deleted_mark_bypass;
    logic dual_head_track;
    logic verify_count_enable;
    logic programmed_io_select;
    logic write_pulse_timing_alter;
    logic perp_bits_write_enable;
    logic drive_sel;
  } fcp_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fcp_bus_t;

  typedef struct packed {
    logic found;
    logic deleted;
    logic byte_tick;
  } fcp_pins_t;

  typedef struct packed {
    logic        req;
    logic        head;
    logic [7:0]  num;
    logic [14:0] bytes;
  } fcp_sec_t;
endpackage

// file: hdl/fcp_sync2.sv
`timescale 1ns/10ps
module fcp_sync2 #(
  parameter int unsigned W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: hdl/fcp_step_timer.sv
`timescale 1ns/10ps
module fcp_step_timer #(
  parameter int unsigned HALF_CYC = fcp_pkg::HALF_MS_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       en,
  input  wire logic [3:0] code,
  output logic            tick
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] half_q;
  logic [3:0]    n_q;

  // interval is (code + 1) half-millisecond units; dropping en restarts it
  wire half_end = (half_q == CW'(HALF_CYC - 1));
  wire last     = half_end && (n_q == code);

  always_ff @(posedge ref_clk) begin
    if (srst || !en) begin
      half_q <= '0;
      n_q    <= 4'h0;
    end else if (half_end) begin
      half_q <= '0;
      n_q    <= last ? 4'h0 : n_q + 4'h1;
    end else begin
      half_q <= half_q + CW'(1);
    end
  end

  assign tick = en & last;
endmodule

// file: hdl/fcp_core.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module fcp_core #(
  parameter int unsigned HALF_MS_CYC_P = fcp_pkg::HALF_MS_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire fcp_pkg::fcp_bus_t  bus_req,
  output logic [7:0]              rd_data,
  input  wire fcp_pkg::fcp_pins_t drive_pins,
  output fcp_pkg::fcp_sec_t       sec_out,
  output logic                    step_pulse,
  output logic                    step_dir,
  output logic                    drive_sel,
  output logic                    write_gate,
  output logic                    precomp_en,
  output logic                    pio_irq,
  output logic                    dma_req,
  output logic                    poll_strobe,
  output logic                    result_avail,
  output logic                    busy
);
  fcp_pkg::fcp_state_t state_q, state_d;
  fcp_pkg::fcp_ctrl_t  ctrl_q;
  fcp_pkg::fcp_cmd_t   cmd_q;
  fcp_pkg::fcp_pins_t  pins_s, pins_p_q;
  logic [7:0]  perp_mode_q, precomp_start_track_q, cylinder_step_delta_q;
  logic [7:0]  start_sector_q, sectors_per_track_q, cur_sec_q, sec_left_q;
  logic [7:0]  steps_q, skip_cnt_q, rd_data_q;
  logic [7:0]  present_cylinder_value_q [fcp_pkg::DRIVES];
  logic [7:0]  result_status_q [4];
  logic [3:0]  head_step_interval_q;
  logic [2:0]  size_code_q;
  logic [14:0] sec_bytes_q, bytes_q;
  logic        dir_q, drv_q, head_q, step_tick, result_q;
  logic        step_q, write_pulse_timing_alter_q, precomp_q, pio_q, dma_q, poll_q;

  fcp_sync2 #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .d       (drive_pins),
    .q       (pins_s)
  );

  wire found_rise = pins_s.found & ~pins_p_q.found;
  wire byte_rise  = pins_s.byte_tick & ~pins_p_q.byte_tick;
  wire deleted    = pins_s.deleted;

  wire st_idle = (state_q == fcp_pkg::ST_IDLE);
  wire st_step = (state_q == fcp_pkg::ST_STEP);
  wire st_sec  = (state_q == fcp_pkg::ST_SEC);
  wire st_data = (state_q == fcp_pkg::ST_DATA);
  wire st_res  = (state_q == fcp_pkg::ST_RES);

  // register decode
  wire [7:0] addr     = bus_req.addr;
  wire [7:0] wdata    = bus_req.wdata;
  wire       wr_ctrl  = bus_req.wr && (addr == fcp_pkg::OFF_CTRL);
  wire       wr_perp  = bus_req.wr && (addr == fcp_pkg::OFF_PERP);
  wire       wr_pre   = bus_req.wr && (addr == fcp_pkg::OFF_PRECOMP_START_TRACK);
  wire       wr_step  = bus_req.wr && (addr == fcp_pkg::OFF_STEP);
  wire       wr_sect  = bus_req.wr && (addr == fcp_pkg::OFF_SECTOR);
  wire       wr_spt   = bus_req.wr && (addr == fcp_pkg::OFF_SPT);
  wire       wr_size  = bus_req.wr && (addr == fcp_pkg::OFF_SIZE);
  wire       wr_delta = bus_req.wr && (addr == fcp_pkg::OFF_DELTA);
  wire       wr_cmd   = bus_req.wr && (addr == fcp_pkg::OFF_CMD);
  wire       rd_res3  = bus_req.rd && (addr == fcp_pkg::OFF_RES3);
  wire       res_hit  = (addr >= fcp_pkg::OFF_RES0) && (addr <= fcp_pkg::OFF_RES3);
  wire [1:0] res_idx  = 2'(addr - fcp_pkg::OFF_RES0);

  wire fcp_pkg::fcp_cmd_t cmd_in = fcp_pkg::fcp_cmd_t'(wdata[2:0]);
  // commands written while busy are dropped
  wire start = wr_cmd && st_idle && (cmd_in != fcp_pkg::CMD_NONE);

  wire is_read = (cmd_q == fcp_pkg::CMD_READ);
  wire is_rdel = (cmd_q == fcp_pkg::CMD_READ_DEL);
  wire is_fmt  = (cmd_q == fcp_pkg::CMD_FORMAT);
  wire is_ver  = (cmd_q == fcp_pkg::CMD_VERIFY);
  wire is_wr   = (cmd_q == fcp_pkg::CMD_WRITE) || is_fmt;
  wire is_seek = (cmd_q == fcp_pkg::CMD_SEEK_REL);
  wire [7:0] pcn_cur = present_cylinder_value_q[drv_q];

  // RQ9 RQ10 RQ11 deleted mark skip
  wire skip = ctrl_q.deleted_mark_bypass & ((is_read & deleted) | (is_rdel & ~deleted));

  // RQ7 RQ8 counted sector runs
  wire cnt_mode = is_fmt | (is_ver & ctrl_q.verify_count_enable);
  wire last_sec = cnt_mode ? (sec_left_q == 8'h01)
                           : (is_ver | (cur_sec_q >= sectors_per_track_q));
  // RQ16 continue on head 1
  wire to_head1 = ctrl_q.dual_head_track & ~head_q & ~is_ver & ~is_fmt;
  wire adv      = (st_sec & found_rise & (skip | is_fmt))
                | (st_data & byte_rise & (bytes_q == 15'h0001));
  wire finish   = adv & last_sec & ~to_head1;

  // RQ3 RQ12 timer shared by stepping and idle polling
  wire timer_en = st_step | (st_idle & ~ctrl_q.poll_disable & ~start);
  fcp_step_timer #(.HALF_CYC(HALF_MS_CYC_P)) u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .en      (timer_en),
    .code    (head_step_interval_q),
    .tick    (step_tick)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      fcp_pkg::ST_IDLE: begin
        if (start && (cmd_in == fcp_pkg::CMD_SEEK_REL))
          state_d = (cylinder_step_delta_q == 8'h00) ? fcp_pkg::ST_RES : fcp_pkg::ST_STEP;
        else if (start && (cmd_in == fcp_pkg::CMD_SENSE))
          state_d = fcp_pkg::ST_RES;
        else if (start)
          state_d = fcp_pkg::ST_SEC;
      end
      fcp_pkg::ST_STEP: if (step_tick && (steps_q == 8'h01)) state_d = fcp_pkg::ST_RES;
      fcp_pkg::ST_SEC: begin
        if (finish)
          state_d = fcp_pkg::ST_RES;
        else if (found_rise && !adv)
          state_d = fcp_pkg::ST_DATA;
      end
      fcp_pkg::ST_DATA: begin
        if (finish)
          state_d = fcp_pkg::ST_RES;
        else if (adv)
          state_d = fcp_pkg::ST_SEC;
      end
      fcp_pkg::ST_RES: state_d = fcp_pkg::ST_IDLE;
      default: state_d = fcp_pkg::ST_IDLE;
    endcase
  end

  // RQ15 pre-erase gate opens while seeking the sector
  wire write_pulse_timing_alter_d = is_wr & (st_data | ((is_fmt | ctrl_q.write_pulse_timing_alter) & st_sec));

  // RQ13 result bytes
  wire [7:0] res0_d = {2'b00, is_seek, 3'b000, head_q, drv_q};
  // RQ2 sense answers present cylinder
  wire [7:0] res1_d = (cmd_q == fcp_pkg::CMD_SENSE || is_seek) ? pcn_cur : cur_sec_q;
  wire [7:0] res3_d = {4'h0, ctrl_q.write_pulse_timing_alter, precomp_q, head_q, drv_q};

  // RQ14 read mux, results readable at any time after capture
  wire [7:0] rd_mux =
      (addr == fcp_pkg::OFF_CTRL)   ? ctrl_q :
      (addr == fcp_pkg::OFF_PERP)   ? perp_mode_q :
      (addr == fcp_pkg::OFF_PRECOMP_START_TRACK) ? precomp_start_track_q :
      (addr == fcp_pkg::OFF_STEP)   ? {4'h0, head_step_interval_q} :
      (addr == fcp_pkg::OFF_SECTOR) ? start_sector_q :
      (addr == fcp_pkg::OFF_SPT)    ? sectors_per_track_q :
      (addr == fcp_pkg::OFF_SIZE)   ? {5'h00, size_code_q} :
      (addr == fcp_pkg::OFF_DELTA)  ? cylinder_step_delta_q :
      res_hit                       ? result_status_q[res_idx] :
      (addr == fcp_pkg::OFF_STAT)   ? {busy, result_q, 6'h00} :
      (addr == fcp_pkg::OFF_PCN)    ? present_cylinder_value_q[ctrl_q.drive_sel] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q                <= fcp_pkg::CTRL_RST;
      perp_mode_q           <= 8'h00;
      precomp_start_track_q <= 8'h00;
      head_step_interval_q  <= fcp_pkg::STEP_RST;
      start_sector_q        <= fcp_pkg::SECTOR_RST;
      sectors_per_track_q   <= fcp_pkg::SPT_RST;
      size_code_q           <= 3'h0;
      cylinder_step_delta_q <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_q <= fcp_pkg::fcp_ctrl_t'(wdata);
      if (wr_perp) perp_mode_q[7:4] <= wdata[7:4];
      // RQ1 low bits locked
      if (wr_perp && ctrl_q.perp_bits_write_enable) perp_mode_q[3:0] <= wdata[3:0];
      // RQ4 full byte range
      if (wr_pre)   precomp_start_track_q <= wdata;
      if (wr_step)  head_step_interval_q <= wdata[3:0];
      if (wr_sect)  start_sector_q <= wdata;
      if (wr_spt)   sectors_per_track_q <= wdata;
      // RQ17 codes above 7 do not exist
      if (wr_size)  size_code_q <= wdata[2:0];
      if (wr_delta) cylinder_step_delta_q <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q  <= fcp_pkg::ST_IDLE;
      pins_p_q <= '0;
      cmd_q    <= fcp_pkg::CMD_NONE;
      {dir_q, drv_q, head_q} <= 3'h0;
      {cur_sec_q, sec_left_q, steps_q, skip_cnt_q} <= 32'h0000_0000;
      sec_bytes_q <= 15'h0000;
      bytes_q     <= 15'h0000;
    end else begin
      state_q  <= state_d;
      pins_p_q <= pins_s;
      if (start) begin
        cmd_q      <= cmd_in;
        dir_q      <= wdata[7];
        drv_q      <= ctrl_q.drive_sel;
        head_q     <= 1'b0;
        // RQ5 first sector from start sector, sector 1 for format
        cur_sec_q  <= (cmd_in == fcp_pkg::CMD_FORMAT) ? 8'h01 : start_sector_q;
        sec_left_q <= sectors_per_track_q;
        steps_q    <= cylinder_step_delta_q;
        skip_cnt_q <= 8'h00;
        // RQ17 bytes per sector
        sec_bytes_q <= 15'(fcp_pkg::SECTOR_BASE_BYTES) << size_code_q;
      end
      if (step_tick && st_step) steps_q <= steps_q - 8'h01;
      if (st_sec && found_rise) bytes_q <= sec_bytes_q;
      if (st_data && byte_rise) bytes_q <= bytes_q - 15'h0001;
      if (adv && st_sec && skip) skip_cnt_q <= skip_cnt_q + 8'h01;
      if (adv && last_sec && to_head1) begin
        head_q    <= 1'b1;
        cur_sec_q <= 8'h01;
      end else if (adv && !last_sec) begin
        cur_sec_q  <= cur_sec_q + 8'h01;
        sec_left_q <= sec_left_q - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < fcp_pkg::DRIVES; i++) present_cylinder_value_q[i] <= 8'h00;
      for (int i = 0; i < 4; i++) result_status_q[i] <= 8'h00;
      {step_q, write_pulse_timing_alter_q, precomp_q, pio_q, dma_q, poll_q, result_q} <= 7'h00;
      rd_data_q <= 8'h00;
    end else begin
      // RQ6 RQ19 relative step on the selected drive only
      if (step_tick && st_step)
        present_cylinder_value_q[drv_q] <= dir_q ? pcn_cur + 8'h01 : pcn_cur - 8'h01;
      step_q    <= step_tick & st_step;
      poll_q    <= step_tick & st_idle;
      write_pulse_timing_alter_q   <= write_pulse_timing_alter_d;
      // RQ4 precomp from start track inward
      precomp_q <= write_pulse_timing_alter_d & (pcn_cur >= precomp_start_track_q);
      // RQ18 per byte service request
      pio_q <= st_data & byte_rise & ~is_ver & ctrl_q.programmed_io_select;
      dma_q <= st_data & byte_rise & ~is_ver & ~ctrl_q.programmed_io_select;
      if (st_res) begin
        result_status_q[0] <= res0_d;
        result_status_q[1] <= res1_d;
        result_status_q[2] <= skip_cnt_q;
        result_status_q[3] <= res3_d;
      end
      // a new result wins over the read that would clear it
      if (st_res) result_q <= 1'b1;
      else if (rd_res3) result_q <= 1'b0;
      rd_data_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign rd_data      = rd_data_q;
  assign sec_out      = '{req: st_sec, head: head_q, num: cur_sec_q, bytes: sec_bytes_q};
  assign step_pulse   = step_q;
  assign step_dir     = dir_q;
  assign drive_sel    = drv_q;
  assign write_gate   = write_pulse_timing_alter_q;
  assign precomp_en   = precomp_q;
  assign pio_irq      = pio_q;
  assign dma_req      = dma_q;
  assign poll_strobe  = poll_q;
  assign result_avail = result_q;
  assign busy         = ~st_idle;

  // helper logic for the checks below
  logic [7:0]  seek_tgt_q, run_cnt_q;
  logic [31:0] gap_q;
  logic        seen_q;
  always_ff @(posedge ref_clk) begin
    if (srst || start) begin
      seek_tgt_q <= wdata[7] ? pcn_cur + cylinder_step_delta_q : pcn_cur - cylinder_step_delta_q;
      run_cnt_q  <= 8'h00;
      gap_q      <= 32'h0000_0000;
      seen_q     <= 1'b0;
    end else begin
      if (adv) run_cnt_q <= run_cnt_q + 8'h01;
      gap_q  <= step_q ? 32'h0000_0001 : gap_q + 32'h0000_0001;
      seen_q <= seen_q | step_q;
    end
  end

  a_perp_low_locked: assert property (@(posedge ref_clk) disable iff (srst) // RQ1
    wr_perp && !ctrl_q.perp_bits_write_enable |=> $stable(perp_mode_q[3:0]))
    else $error("perp low bits changed while locked");
  a_sense_pcn: assert property (@(posedge ref_clk) disable iff (srst) // RQ2
    st_res && cmd_q == fcp_pkg::CMD_SENSE |=> result_status_q[1] == $past(pcn_cur))
    else $error("sense result lacks present cylinder");
  a_poll_stopped: assert property (@(posedge ref_clk) disable iff (srst) // RQ3
    $past(ctrl_q.poll_disable) |-> !poll_strobe)
    else $error("polling while disabled");
  a_precomp_track: assert property (@(posedge ref_clk) disable iff (srst) // RQ4
    precomp_en |-> $past(pcn_cur >= precomp_start_track_q) && write_gate)
    else $error("precomp below start track");
  a_first_sector: assert property (@(posedge ref_clk) disable iff (srst) // RQ5
    start && cmd_in inside {fcp_pkg::CMD_READ, fcp_pkg::CMD_WRITE}
    |=> sec_out.req && sec_out.num == $past(start_sector_q))
    else $error("first sector not start sector");
  a_seek_relative: assert property (@(posedge ref_clk) disable iff (srst) // RQ6
    st_res && is_seek |-> pcn_cur == seek_tgt_q)
    else $error("relative seek ended off target");
  a_format_count: assert property (@(posedge ref_clk) disable iff (srst) // RQ7
    st_res && is_fmt |-> run_cnt_q == sectors_per_track_q)
    else $error("format header count wrong");
  a_verify_count: assert property (@(posedge ref_clk) disable iff (srst) // RQ8
    st_res && is_ver && ctrl_q.verify_count_enable |-> run_cnt_q == sectors_per_track_q)
    else $error("verify sector count wrong");
  a_skip_deleted: assert property (@(posedge ref_clk) disable iff (srst) // RQ9
    st_sec && found_rise && is_read && deleted && ctrl_q.deleted_mark_bypass |=> !st_data)
    else $error("deleted sector not skipped");
  a_rdel_only: assert property (@(posedge ref_clk) disable iff (srst) // RQ10
    st_sec && found_rise && is_rdel && !deleted && ctrl_q.deleted_mark_bypass |=> !st_data)
    else $error("normal sector read by read deleted");
  a_no_skip: assert property (@(posedge ref_clk) disable iff (srst) // RQ11
    st_sec && found_rise && (is_read || is_rdel) && !ctrl_q.deleted_mark_bypass |=> st_data)
    else $error("sector skipped with bypass clear");
  a_step_gap: assert property (@(posedge ref_clk) disable iff (srst) // RQ12
    step_pulse && seen_q |-> gap_q == (32'(head_step_interval_q) + 1) * HALF_MS_CYC_P)
    else $error("step interval wrong");
  a_result_phase: assert property (@(posedge ref_clk) disable iff (srst) // RQ13
    st_res |=> result_avail && !busy)
    else $error("result not posted");
  a_result_read: assert property (@(posedge ref_clk) disable iff (srst) // RQ14
    bus_req.rd && bus_req.addr == fcp_pkg::OFF_RES0 |=> rd_data == result_status_q[0])
    else $error("result byte not returned");
  a_write_pulse_timing_alter_shift: assert property (@(posedge ref_clk) disable iff (srst) // RQ15
    st_sec && cmd_q == fcp_pkg::CMD_WRITE |=> write_gate == $past(ctrl_q.write_pulse_timing_alter))
    else $error("write gate timing wrong");
  a_dual_head: assert property (@(posedge ref_clk) disable iff (srst) // RQ16
    adv && last_sec && to_head1 |=> sec_out.head && sec_out.num == 8'h01 && st_sec)
    else $error("no switch to head 1");
  a_xfer_kind: assert property (@(posedge ref_clk) disable iff (srst) // RQ18
    st_data && byte_rise && !is_ver
    |=> pio_irq == $past(ctrl_q.programmed_io_select) && dma_req == !pio_irq)
    else $error("wrong transfer request kind");
  a_other_drive: assert property (@(posedge ref_clk) disable iff (srst) // RQ19
    st_step |=> $stable(present_cylinder_value_q[!drv_q]))
    else $error("unselected drive cylinder moved");

  c_seek_done: cover property (@(posedge ref_clk) st_res && is_seek && seen_q);
  c_skip_seen: cover property (@(posedge ref_clk) adv && st_sec && skip);
  c_head1_run: cover property (@(posedge ref_clk) st_data && head_q);
endmodule

// file: verif/fcp_drive_model.sv
`timescale 1ns/10ps
module fcp_drive_model (
  input  wire logic              ref_clk,
  input  wire fcp_pkg::fcp_sec_t sec,
  input  wire logic [15:0]       del_mask,
  input  wire logic              slow,
  output fcp_pkg::fcp_pins_t     pins
);
  int n;
  initial begin
    pins = '0;
    forever begin
      @(posedge ref_clk);
      if (sec.req) begin
        n = sec.bytes;
        repeat (slow ? 40 : 4) @(posedge ref_clk);
        pins.found   <= 1'b1;
        pins.deleted <= del_mask[sec.num[3:0]];
        repeat (3) @(posedge ref_clk);
        pins.found   <= 1'b0;
        // released mark line must not keep its value
        pins.deleted <= ~pins.deleted;
        repeat (n) begin
          repeat (3) @(posedge ref_clk);
          pins.byte_tick <= 1'b1;
          repeat (3) @(posedge ref_clk);
          pins.byte_tick <= 1'b0;
        end
      end
    end
  end
endmodule

// file: verif/tb_floppy_cmd_param_handling.sv
`timescale 1ns/10ps
module tb_floppy_cmd_param_handling;
  localparam int unsigned HC = 4;
  logic               ref_clk, srst, slow, pr, saw_pc, saw_wg;
  fcp_pkg::fcp_bus_t  bus;
  fcp_pkg::fcp_pins_t pins;
  fcp_pkg::fcp_sec_t  sec;
  logic [7:0]         rd_data, r, pn;
  logic [7:0]         res [4];
  logic [15:0]        mask;
  logic               step_pulse, step_dir, drive_sel, write_gate, precomp_en;
  logic               pio_irq, dma_req, poll_strobe, result_avail, busy;
  int                 bad_count, checked, cyc, n_hdr, n_dma, n_irq, gap, last, np;
  int                 s, n, e, d, c;
  logic [7:0]         rv [8] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h01, 8'h01, 8'h00, 8'h00};
  fcp_core #(.HALF_MS_CYC_P(HC)) uut (.ref_clk(ref_clk), .srst(srst), .bus_req(bus),
    .rd_data(rd_data), .drive_pins(pins), .sec_out(sec), .step_pulse(step_pulse),
    .step_dir(step_dir), .drive_sel(drive_sel), .write_gate(write_gate),
    .precomp_en(precomp_en), .pio_irq(pio_irq), .dma_req(dma_req),
    .poll_strobe(poll_strobe), .result_avail(result_avail), .busy(busy));
  fcp_drive_model drv (.ref_clk(ref_clk), .sec(sec), .del_mask(mask), .slow(slow),
    .pins(pins));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] g);
    checked++;
    if (g !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] dv);
    @(posedge ref_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= dv;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] dv);
    @(posedge ref_clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    dv = rd_data;
  endtask
  task automatic count_poll();
    np = 0;
    repeat (100) begin
      @(posedge ref_clk);
      #1;
      np += poll_strobe;
    end
  endtask
  // one command, watched until its results stand, then all four bytes read
  task automatic run(logic [7:0] cm);
    wr(fcp_pkg::OFF_CMD, cm);
    n_hdr = 0;
    n_dma = 0;
    n_irq = 0;
    last = 0;
    saw_pc = 1'b0;
    saw_wg = 1'b0;
    pr = 1'b0;
    pn = 8'h00;
    for (int i = 0; i < 60000 && result_avail !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      // skipped and formatted sectors keep req high, so a new number is a new header
      if (sec.req === 1'b1 && (!pr || sec.num != pn)) n_hdr++;
      pr = sec.req;
      pn = sec.num;
      n_dma += dma_req;
      n_irq += pio_irq;
      saw_pc |= precomp_en;
      saw_wg |= write_gate;
      if (step_pulse === 1'b1) begin
        gap = i - last;
        last = i;
      end
    end
    for (int k = 0; k < 4; k++) rd(fcp_pkg::OFF_RES0 + 8'(k), res[k]);
    chk("busy", 16'h0000, 16'(busy));
  endtask
  function automatic int exp_skip(int fs, int fn, logic [15:0] m, logic dm);
    int cnt = 0;
    for (int j = fs; j <= fn; j++) cnt += int'(m[j] ^ dm);
    return cnt;
  endfunction
  task automatic results();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    bus = '0;
    srst = 1'b1;
    slow = 1'b0;
    mask = 16'h0000;
    void'($urandom(32'h8f04ebca));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++) begin
      rd(8'(a), r);
      chk("reset value", 16'(rv[a]), 16'(r));
    end
    rd(8'h20, r);
    chk("unmapped", 16'h0000, 16'(r));
    count_poll();
    chk("poll on", 16'h0001, 16'(np > 0));
    wr(fcp_pkg::OFF_CTRL, 8'h80);
    count_poll();
    chk("poll off", 16'h0000, 16'(np));
    wr(fcp_pkg::OFF_PERP, 8'hff);
    rd(fcp_pkg::OFF_PERP, r);
    chk("perp locked", 16'h00f0, 16'(r));
    wr(fcp_pkg::OFF_CTRL, 8'h02);
    wr(fcp_pkg::OFF_PERP, 8'h5a);
    rd(fcp_pkg::OFF_PERP, r);
    chk("perp open", 16'h005a, 16'(r));
    $display("test registers done");
    c = $urandom_range(3);
    d = 2 + $urandom_range(2);
    wr(fcp_pkg::OFF_STEP, 8'(c));
    wr(fcp_pkg::OFF_DELTA, 8'(d));
    run(8'h86);
    chk("step gap", 16'((c + 1) * HC), 16'(gap));
    chk("seek cyl", 16'(d), 16'(res[1]));
    chk("step dir", 16'h0001, 16'(step_dir));
    run(8'h07);
    chk("sense cyl", 16'(d), 16'(res[1]));
    chk("drive sel", 16'h0000, 16'(drive_sel));
    wr(fcp_pkg::OFF_CTRL, 8'h01);
    rd(fcp_pkg::OFF_PCN, r);
    chk("drive1 cyl", 16'h0000, 16'(r));
    $display("test seek done");
    wr(fcp_pkg::OFF_CTRL, 8'h04);
    for (int t = 0; t < 2; t++) begin
      wr(fcp_pkg::OFF_PRECOMP_START_TRACK, 8'(d + t));
      run(8'h03);
      chk("precomp", 16'(t == 0), 16'(saw_pc));
      chk("write gate", 16'h0001, 16'(saw_wg));
      chk("alter flag", 16'h0001, 16'(res[3][3]));
    end
    $display("test write done");
    for (int t = 0; t < 3; t++) begin
      s = 1 + $urandom_range(2);
      n = s + 1 + $urandom_range(3);
      mask = 16'($urandom);
      slow = 1'($urandom_range(1));
      wr(fcp_pkg::OFF_SECTOR, 8'(s));
      wr(fcp_pkg::OFF_SPT, 8'(n));
      wr(fcp_pkg::OFF_CTRL, {1'b0, t != 2, 2'b00, t == 2, 3'b000});
      run(t == 1 ? 8'h02 : 8'h01);
      e = (t == 2) ? 0 : exp_skip(s, n, mask, t == 1);
      chk("skipped", 16'(e), 16'(res[2]));
      chk("last sector", 16'(n), 16'(res[1]));
      chk("headers", 16'(n - s + 1), 16'(n_hdr));
      chk("bytes", 16'((n - s + 1 - e) * 128), 16'(t == 2 ? n_irq : n_dma));
      chk("other path", 16'h0000, 16'(t == 2 ? n_dma : n_irq));
    end
    $display("test read done");
    for (int t = 0; t < 3; t++) begin
      wr(fcp_pkg::OFF_CTRL, t == 1 ? 8'h10 : 8'h00);
      run(t == 0 ? 8'h04 : 8'h05);
      chk("header count", 16'(t == 2 ? 1 : n), 16'(n_hdr));
    end
    $display("test format verify done");
    results();
  end
endmodule
